// ===== bisync_pkg.sv
// bisync_pkg: register offsets, field positions, reset values and shared types
// assumes a plain address/strobe register port with 16-bit data
package bisync_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] OFF_SYNC_CHAR = 4'h0;
    localparam logic [3:0] OFF_DLE_CHAR = 4'h1;
    localparam logic [3:0] OFF_SYNC_PATTERN = 4'h2;
    localparam logic [3:0] OFF_MODE = 4'h3;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_MASK = 4'h5;
    localparam logic [3:0] OFF_CTRL_TABLE = 4'h8;
    localparam int CTRL_ENTRIES = 4;
    localparam int VALID_BIT = 15;
    localparam int MODE_SYNC_LENGTH_FIELD_LSB = 0;
    localparam int MODE_TRANSP_BIT = 2;
    localparam int MODE_HUNT_BIT = 3;
    localparam int CT_REJECT_BIT = 14;
    localparam logic [15:0] RST_SYNC_CHAR = 16'h0000;
    localparam logic [15:0] RST_DLE_CHAR = 16'h0000;
    localparam logic [15:0] RST_SYNC_PATTERN = 16'h0000;
    localparam logic [15:0] RST_MODE = 16'h0008;
    localparam int EV_DLE_ERR = 0;
    localparam int EV_CTRL = 1;
    localparam int EV_SYNC_LOCK = 2;
    localparam int EV_UNDERRUN = 3;
    localparam int EV_W = 4;
    typedef enum logic [1:0] {
        SYNC_LENGTH_FIELD_NONE = 2'h0,
        SYNC_LENGTH_FIELD_4 = 2'h1,
        SYNC_LENGTH_FIELD_8 = 2'h2,
        SYNC_LENGTH_FIELD_16 = 2'h3
    } sync_length_field_type;
    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_SYNC = 4'h2,
        TX_DATA = 4'h4,
        TX_FILL = 4'h8
    } tx_state_type;
endpackage

// ===== bisync_sync_dle_handler.sv
// bisync_sync_dle_handler: sync hunt, sync/dle stripping, dle-sync fill on transparent underrun
// assumes bytes arrive already deserialised with a bit-level hunt input alongside
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps

// Notes on behaviour
// - out of hunt, valid sync character dropped
// - dle register: valid bit, zeros, low byte
// - transparent underrun sends dle-sync pairs
// - transparent valid dle discarded, no check update
// - sync after dle discarded, no check update
// - dle after dle stored and checked
// - other follower looked up in control table
// - follower not in table closes with error
// - dle invalid: dle treated as data
// - receiver locks on 4, 8 or 16 bit pattern
// - whole pattern register sent lsb first
module bisync_sync_dle_handler
    import bisync_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clkEn,
    // register port
    input wire logic [bisync_pkg::ADDR_W-1:0] regAddr,
    input wire logic [bisync_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [bisync_pkg::DATA_W-1:0] regRdData,
    output logic irq,
    // serial line
    input wire logic rxBit,
    input wire logic rxBitValid,
    output logic txBit,
    output logic txBitValid,
    // receive characters from the deframer
    input wire logic [7:0] rxChar,
    input wire logic rxCharValid,
    output logic [7:0] bufChar,
    output logic bufCharValid,
    output logic bcsUpdate,
    output logic bufClose,
    output logic dleFollowErrorFlag,
    output logic rxLocked,
    // transmit characters
    input wire logic frameStart,
    input wire logic [7:0] txChar,
    input wire logic txCharValid,
    input wire logic txUnderrun,
    output logic txCharReady
);
    import bisync_pkg::*;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [15:0] syncCharReg, next_syncCharReg;
    logic [15:0] dleCharReg, next_dleCharReg;
    logic [15:0] syncPatternReg, next_syncPatternReg;
    logic [15:0] modeReg, next_modeReg;
    logic [EV_W-1:0] status, next_status;
    logic [EV_W-1:0] mask, next_mask;
    logic [15:0] ctrlTable [CTRL_ENTRIES];
    logic [15:0] next_ctrlTable [CTRL_ENTRIES];
    logic [15:0] rdData, next_rdData;
    logic [EV_W-1:0] events;
    sync_length_field_type sync_length_field;
    logic transparent;
    logic hunt;
    tx_state_type txState, next_txState;

    assign sync_length_field = sync_length_field_type'(modeReg[MODE_SYNC_LENGTH_FIELD_LSB +: 2]);
    assign transparent = modeReg[MODE_TRANSP_BIT];
    assign hunt = modeReg[MODE_HUNT_BIT];

    always_comb begin
        next_syncCharReg = syncCharReg;
        next_dleCharReg = dleCharReg;
        next_syncPatternReg = syncPatternReg;
        next_modeReg = modeReg;
        next_mask = mask;
        next_rdData = rdData;
        next_status = status | events;
        for (int i = 0; i < CTRL_ENTRIES; i++) begin
            next_ctrlTable[i] = ctrlTable[i];
        end
        if (rxLocked && hunt) begin
            next_modeReg[MODE_HUNT_BIT] = 1'b0;
        end
        if (regWrite) begin
            if (regAddr == OFF_SYNC_CHAR) begin
                next_syncCharReg = regWrData & 16'h80FF;
            end else if (regAddr == OFF_DLE_CHAR) begin
                next_dleCharReg = regWrData & 16'h80FF;
            end else if (regAddr == OFF_SYNC_PATTERN) begin
                next_syncPatternReg = regWrData;
            end else if (regAddr == OFF_MODE) begin
                next_modeReg = regWrData & 16'h000F;
            end else if (regAddr == OFF_STATUS) begin
                next_status = (status & ~regWrData[EV_W-1:0]) | events;
            end else if (regAddr == OFF_MASK) begin
                next_mask = regWrData[EV_W-1:0];
            end else if (regAddr[3] == 1'b1 && regAddr[2:0] < 3'(CTRL_ENTRIES)) begin
                next_ctrlTable[regAddr[1:0]] = regWrData & 16'hC0FF;
            end
        end
        if (regRead) begin
            if (regAddr == OFF_SYNC_CHAR) begin
                next_rdData = syncCharReg;
            end else if (regAddr == OFF_DLE_CHAR) begin
                next_rdData = dleCharReg;
            end else if (regAddr == OFF_SYNC_PATTERN) begin
                next_rdData = syncPatternReg;
            end else if (regAddr == OFF_MODE) begin
                next_rdData = modeReg;
            end else if (regAddr == OFF_STATUS) begin
                next_rdData = {12'h000, status};
            end else if (regAddr == OFF_MASK) begin
                next_rdData = {12'h000, mask};
            end else if (regAddr[3] == 1'b1 && regAddr[2:0] < 3'(CTRL_ENTRIES)) begin
                next_rdData = ctrlTable[regAddr[1:0]];
            end else begin
                next_rdData = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            syncCharReg <= RST_SYNC_CHAR;
            dleCharReg <= RST_DLE_CHAR;
            syncPatternReg <= RST_SYNC_PATTERN;
            modeReg <= RST_MODE;
            status <= '0;
            mask <= '0;
            rdData <= 16'h0000;
            for (int i = 0; i < CTRL_ENTRIES; i++) begin
                ctrlTable[i] <= 16'h0000;
            end
        end else if (clkEn) begin
            syncCharReg <= next_syncCharReg;
            dleCharReg <= next_dleCharReg;
            syncPatternReg <= next_syncPatternReg;
            modeReg <= next_modeReg;
            status <= next_status;
            mask <= next_mask;
            rdData <= next_rdData;
            for (int i = 0; i < CTRL_ENTRIES; i++) begin
                ctrlTable[i] <= next_ctrlTable[i];
            end
        end
    end

    assign regRdData = rdData;
    assign irq = |(status & mask);

    // ----------------------------------------------------------------
    // receive sync hunt
    // ----------------------------------------------------------------
    logic [15:0] shiftIn, next_shiftIn;
    logic locked, next_locked;
    logic patMatch;

    always_comb begin
        case (sync_length_field)
            SYNC_LENGTH_FIELD_4: patMatch = shiftIn[15:12] == syncPatternReg[3:0];
            SYNC_LENGTH_FIELD_8: patMatch = shiftIn[15:8] == syncPatternReg[7:0];
            SYNC_LENGTH_FIELD_16: patMatch = shiftIn == syncPatternReg;
            default: patMatch = 1'b0;
        endcase
    end

    always_comb begin
        next_shiftIn = shiftIn;
        next_locked = locked;
        if (rxBitValid) begin
            next_shiftIn = {rxBit, shiftIn[15:1]};
        end
        if (hunt && !locked && patMatch) begin
            next_locked = 1'b1;
        end else if (hunt && locked) begin
            next_locked = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shiftIn <= 16'h0000;
            locked <= 1'b0;
        end else if (clkEn) begin
            shiftIn <= next_shiftIn;
            locked <= next_locked;
        end
    end

    assign rxLocked = locked;

    // ----------------------------------------------------------------
    // receive character filter
    // ----------------------------------------------------------------
    logic afterDle, next_afterDle;
    logic [7:0] outChar, next_outChar;
    logic outValid, next_outValid, outBcs, next_outBcs;
    logic outClose, next_outClose, outErr, next_outErr;
    logic isSync, isDle, dleOn;
    logic [CTRL_ENTRIES-1:0] ctHit;
    logic ctAny, ctReject;

    assign isSync = rxChar == syncCharReg[7:0];
    assign isDle = rxChar == dleCharReg[7:0];
    assign dleOn = transparent && dleCharReg[VALID_BIT];

    generate
        for (genvar g = 0; g < CTRL_ENTRIES; g++) begin : gCt
            assign ctHit[g] = ctrlTable[g][VALID_BIT] && ctrlTable[g][7:0] == rxChar;
        end
    endgenerate

    always_comb begin
        ctAny = |ctHit;
        ctReject = 1'b0;
        for (int i = 0; i < CTRL_ENTRIES; i++) begin
            if (ctHit[i] && ctrlTable[i][CT_REJECT_BIT]) begin
                ctReject = 1'b1;
            end
        end
    end

    always_comb begin
        next_afterDle = afterDle;
        next_outChar = outChar;
        next_outValid = 1'b0;
        next_outBcs = 1'b0;
        next_outClose = 1'b0;
        next_outErr = 1'b0;
        events = '0;
        if (rxCharValid && !hunt) begin
            next_outChar = rxChar;
            if (afterDle) begin
                next_afterDle = 1'b0;
                if (isSync) begin
                    next_outValid = 1'b0;
                end else if (isDle) begin
                    next_outValid = 1'b1;
                    next_outBcs = 1'b1;
                end else if (ctAny) begin
                    next_outValid = !ctReject;
                    next_outClose = !ctReject;
                    events[EV_CTRL] = 1'b1;
                end else begin
                    next_outClose = 1'b1;
                    next_outErr = 1'b1;
                    events[EV_DLE_ERR] = 1'b1;
                end
            end else if (dleOn && isDle) begin
                next_afterDle = 1'b1;
            end else if (isSync && syncCharReg[VALID_BIT]) begin
                next_outValid = 1'b0;
            end else begin
                next_outValid = 1'b1;
                next_outBcs = 1'b1;
            end
        end
        if (hunt) begin
            next_afterDle = 1'b0;
        end
        events[EV_SYNC_LOCK] = hunt && !locked && patMatch;
        events[EV_UNDERRUN] = txState == TX_DATA && txUnderrun;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            afterDle <= 1'b0;
            outChar <= 8'h00;
            outValid <= 1'b0;
            outBcs <= 1'b0;
            outClose <= 1'b0;
            outErr <= 1'b0;
        end else if (clkEn) begin
            afterDle <= next_afterDle;
            outChar <= next_outChar;
            outValid <= next_outValid;
            outBcs <= next_outBcs;
            outClose <= next_outClose;
            outErr <= next_outErr;
        end
    end

    assign bufChar = outChar;
    assign bufCharValid = outValid;
    assign bcsUpdate = outBcs;
    assign bufClose = outClose;
    assign dleFollowErrorFlag = outErr;

    // ----------------------------------------------------------------
    // transmit sync pattern and underrun fill
    // ----------------------------------------------------------------
    logic [3:0] bitCnt, next_bitCnt;
    logic fillSync, next_fillSync;
    logic outBit, next_outBit, outBitValid, next_outBitValid;
    logic [7:0] fillChar;

    assign fillChar = fillSync ? syncCharReg[7:0] : dleCharReg[7:0];

    always_comb begin
        next_txState = txState;
        next_bitCnt = bitCnt;
        next_fillSync = fillSync;
        next_outBit = 1'b1;
        next_outBitValid = 1'b0;
        txCharReady = 1'b0;
        case (txState)
            TX_IDLE: begin
                if (frameStart) begin
                    next_bitCnt = 4'h0;
                    next_txState = sync_length_field == SYNC_LENGTH_FIELD_NONE ? TX_DATA : TX_SYNC;
                end
            end
            TX_SYNC: begin
                next_outBit = syncPatternReg[bitCnt];
                next_outBitValid = 1'b1;
                next_bitCnt = bitCnt + 4'h1;
                if (bitCnt == 4'hF) begin
                    next_txState = TX_DATA;
                end
            end
            TX_DATA: begin
                txCharReady = 1'b1;
                if (txUnderrun && transparent) begin
                    next_fillSync = 1'b0;
                    next_bitCnt = 4'h0;
                    next_txState = TX_FILL;
                end else if (txUnderrun) begin
                    next_txState = TX_IDLE;
                end
            end
            default: begin
                next_outBit = fillChar[bitCnt[2:0]];
                next_outBitValid = 1'b1;
                next_bitCnt = {1'b0, bitCnt[2:0] + 3'h1};
                if (bitCnt[2:0] == 3'h7) begin
                    next_fillSync = !fillSync;
                    if (fillSync && txCharValid) begin
                        next_txState = TX_DATA;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txState <= TX_IDLE;
            bitCnt <= 4'h0;
            fillSync <= 1'b0;
            outBit <= 1'b1;
            outBitValid <= 1'b0;
        end else if (clkEn) begin
            txState <= next_txState;
            bitCnt <= next_bitCnt;
            fillSync <= next_fillSync;
            outBit <= next_outBit;
            outBitValid <= next_outBitValid;
        end
    end

    assign txBit = outBit;
    assign txBitValid = outBitValid;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_sync_drop;
        @(posedge clk) disable iff (!rst_b)
        clkEn && rxCharValid && !hunt && !afterDle && isSync && syncCharReg[VALID_BIT]
            && !(dleOn && isDle) |=> !bufCharValid;
    endproperty
    a_sync_drop: assert property (p_sync_drop) else $error("sync char stored");

    property p_dle_strip;
        @(posedge clk) disable iff (!rst_b)
        clkEn && rxCharValid && !hunt && !afterDle && dleOn && isDle
            |=> !bufCharValid && !bcsUpdate && afterDle;
    endproperty
    a_dle_strip: assert property (p_dle_strip) else $error("dle not stripped");

    property p_dle_sync;
        @(posedge clk) disable iff (!rst_b)
        clkEn && rxCharValid && !hunt && afterDle && isSync |=> !bufCharValid && !bcsUpdate;
    endproperty
    a_dle_sync: assert property (p_dle_sync) else $error("sync after dle kept");

    property p_dle_dle;
        @(posedge clk) disable iff (!rst_b)
        clkEn && rxCharValid && !hunt && afterDle && !isSync && isDle
            |=> bufCharValid && bcsUpdate && bufChar == $past(rxChar);
    endproperty
    a_dle_dle: assert property (p_dle_dle) else $error("second dle lost");

    property p_dle_err;
        @(posedge clk) disable iff (!rst_b)
        clkEn && rxCharValid && !hunt && afterDle && !isSync && !isDle && !ctAny
            |=> bufClose && dleFollowErrorFlag ##1 status[EV_DLE_ERR];
    endproperty
    a_dle_err: assert property (p_dle_err) else $error("follow error missing");

    property p_dle_plain;
        @(posedge clk) disable iff (!rst_b)
        clkEn && rxCharValid && !hunt && !afterDle && !dleCharReg[VALID_BIT] && isDle
            && !(isSync && syncCharReg[VALID_BIT]) |=> bufCharValid && bcsUpdate;
    endproperty
    a_dle_plain: assert property (p_dle_plain) else $error("plain dle dropped");

    property p_sync_tx;
        @(posedge clk) disable iff (!rst_b)
        clkEn && txState == TX_IDLE && frameStart && sync_length_field != SYNC_LENGTH_FIELD_NONE
            |=> txState == TX_SYNC ##1 txBitValid && txBit == $past(syncPatternReg[0], 2);
    endproperty
    a_sync_tx: assert property (p_sync_tx) else $error("pattern not sent");

    property p_no_sync_tx;
        @(posedge clk) disable iff (!rst_b)
        clkEn && txState == TX_IDLE && frameStart && sync_length_field == SYNC_LENGTH_FIELD_NONE |=> txState == TX_DATA;
    endproperty
    a_no_sync_tx: assert property (p_no_sync_tx) else $error("pattern sent");

    property p_fill;
        @(posedge clk) disable iff (!rst_b)
        clkEn && txState == TX_DATA && txUnderrun && transparent |=> txState == TX_FILL;
    endproperty
    a_fill: assert property (p_fill) else $error("no dle-sync fill");

    c_lock: cover property (@(posedge clk) disable iff (!rst_b) hunt && patMatch ##1 locked);
    c_fill: cover property (@(posedge clk) disable iff (!rst_b) txState == TX_FILL);
    c_err: cover property (@(posedge clk) disable iff (!rst_b) dleFollowErrorFlag);
endmodule

// ===== bisync_remote_station.sv
// bisync_remote_station: behavioural far-end station on the serial line
// assumes one clock shared with the block; drives just after rising edges
`timescale 1ns/100ps
module bisync_remote_station (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // toward the block
    output logic rxBit,
    output logic rxBitValid,
    output logic [7:0] rxChar,
    output logic rxCharValid,
    // from the block
    input wire logic txBit,
    input wire logic txBitValid
);
    initial begin
        rxBit = 1'b0;
        rxBitValid = 1'b0;
        rxChar = 8'h00;
        rxCharValid = 1'b0;
    end
    // --------------------------------------------------------------
    // line tasks
    // --------------------------------------------------------------
    // bits go lsb first; a released line shows the inverse of the last bit
    task automatic sendBits(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rxBit <= v[i];
            rxBitValid <= 1'b1;
        end
        @(posedge clk);
        rxBit <= ~v[n-1];
        rxBitValid <= 1'b0;
    endtask
    task automatic sendChar(input logic [7:0] c);
        @(posedge clk);
        rxChar <= c;
        rxCharValid <= 1'b1;
        @(posedge clk);
        rxChar <= ~c;
        rxCharValid <= 1'b0;
    endtask
    // collects 16 transmitted bits, first bit into bit 0
    task automatic grabBits(output logic [15:0] v, output logic ok);
        int n;
        n = 0;
        v = 16'h0000;
        for (int t = 0; t < 400 && n < 16; t++) begin
            @(posedge clk);
            #1;
            if (txBitValid === 1'b1) begin
                v = {txBit, v[15:1]};
                n++;
            end
        end
        ok = (n == 16);
    endtask
endmodule

// ===== tb_top.sv
// tb_top: self-checking bench for the sync and dle handler
// assumes a 20 MHz clock and the remote station model on the far side
`timescale 1ns/100ps
module tb_top;
    import bisync_pkg::*;
    logic clk, rst_b, regWrite, regRead, irq, rxBit, rxBitValid, txBit, txBitValid;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData, regRdData, rdv, pat, v;
    logic [7:0] rxChar, bufChar, txChar, seenBuf, c;
    logic rxCharValid, bufCharValid, bcsUpdate, bufClose, dleFollowErrorFlag, rxLocked;
    logic frameStart, txCharValid, txUnderrun, txCharReady, ok, clkEn;
    logic [3:0] seenRx;
    int errTotal, checked, n;
    int unsigned seed = 80822;
    // --------------------------------------------------------------
    // design and partner
    // --------------------------------------------------------------
    bisync_sync_dle_handler i_dut (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .irq(irq), .rxBit(rxBit), .rxBitValid(rxBitValid),
        .txBit(txBit), .txBitValid(txBitValid), .rxChar(rxChar), .rxCharValid(rxCharValid),
        .bufChar(bufChar), .bufCharValid(bufCharValid), .bcsUpdate(bcsUpdate),
        .bufClose(bufClose), .dleFollowErrorFlag(dleFollowErrorFlag), .rxLocked(rxLocked),
        .frameStart(frameStart), .txChar(txChar), .txCharValid(txCharValid),
        .txUnderrun(txUnderrun), .txCharReady(txCharReady));
    bisync_remote_station i_remote (.clk(clk), .rst_b(rst_b), .rxBit(rxBit),
        .rxBitValid(rxBitValid), .rxChar(rxChar), .rxCharValid(rxCharValid),
        .txBit(txBit), .txBitValid(txBitValid));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errTotal++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        d = regRdData;
    endtask
    task automatic doReset();
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
    endtask
    task automatic pulseFrame();
        @(posedge clk);
        frameStart <= 1'b1;
        @(posedge clk);
        frameStart <= 1'b0;
    endtask
    // flags are {stored, check update, close, error}
    task automatic rxTest(input logic [7:0] ch, input logic [3:0] exp, input logic [3:0] msk);
        seenRx = 4'h0;
        i_remote.sendChar(ch);
        // the flags stand one cycle from the edge that takes the character
        for (int i = 0; i < 3; i++) begin
            #1;
            seenRx = seenRx | {bufCharValid, bcsUpdate, bufClose, dleFollowErrorFlag};
            if (bufCharValid === 1'b1) seenBuf = bufChar;
            @(posedge clk);
        end
        chk(16'(seenRx & msk), 16'(exp & msk));
        if (exp[3]) chk(16'(seenBuf), 16'(ch));
    endtask
    task automatic lockTest(input logic [1:0] len, input int nb);
        pat = rnd() | 16'h0001;
        if (len == 2'h1) pat = {4{pat[3:0]}};
        if (len == 2'h2) pat = {2{pat[7:0]}};
        // pattern and a flushed shift register first, so hunt cannot lock early
        wr(OFF_SYNC_PATTERN, pat);
        i_remote.sendBits(16'h0000, 16);
        wr(OFF_MODE, 16'h0008 | 16'(len));
        wr(OFF_STATUS, 16'h000F);
        i_remote.sendBits(pat, nb);
        @(posedge clk);
        #1;
        chk(16'(rxLocked), 16'h0001);
        rdv = 16'h0000;
        for (int i = 0; i < 10 && rdv[2] !== 1'b1; i++) rd(OFF_STATUS, rdv);
        chk(rdv & 16'h0004, 16'h0004);
        rd(OFF_MODE, rdv);
        chk(rdv & 16'h0008, 16'h0000);
    endtask
    // --------------------------------------------------------------
    // sequence
    // --------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        regAddr = 4'h0;
        regWrData = 16'h0000;
        regWrite = 1'b0;
        regRead = 1'b0;
        frameStart = 1'b0;
        txChar = 8'h00;
        txCharValid = 1'b0;
        txUnderrun = 1'b0;
        clkEn = 1'b1;
        seenRx = 4'h0;
        seenBuf = 8'h00;
        doReset();
        for (int i = 0; i < 7; i++) begin
            rd(4'(i), rdv);
            chk(rdv, (i == 3) ? 16'h0008 : 16'h0000);
        end
        wr(4'h6, 16'hFFFF);
        rd(4'h6, rdv);
        chk(rdv, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            wr(OFF_DLE_CHAR, v);
            rd(OFF_DLE_CHAR, rdv);
            chk(rdv, v & 16'h80FF);
        end
        // state stands still while the clock enable is low
        @(posedge clk);
        clkEn <= 1'b0;
        wr(OFF_SYNC_CHAR, 16'hFFFF);
        @(posedge clk);
        clkEn <= 1'b1;
        rd(OFF_SYNC_CHAR, rdv);
        chk(rdv, 16'h0000);
        $display("register test done");
        lockTest(2'h3, 16);
        wr(OFF_MASK, 16'h0004);
        @(posedge clk);
        #1;
        chk(16'(irq), 16'h0001);
        wr(OFF_STATUS, 16'h0004);
        @(posedge clk);
        #1;
        chk(16'(irq), 16'h0000);
        lockTest(2'h2, 8);
        lockTest(2'h1, 4);
        $display("hunt test done");
        wr(OFF_MODE, 16'h0004);
        wr(OFF_SYNC_CHAR, 16'h80B2);
        wr(OFF_DLE_CHAR, 16'h8090);
        wr(OFF_CTRL_TABLE, 16'h8003);
        wr(OFF_CTRL_TABLE + 4'h1, 16'hC004);
        rxTest(8'h41, 4'hC, 4'hF);
        rxTest(8'hB2, 4'h0, 4'hF);
        rxTest(8'h90, 4'h0, 4'hF);
        rxTest(8'hB2, 4'h0, 4'hF);
        rxTest(8'h90, 4'h0, 4'hF);
        rxTest(8'h90, 4'hC, 4'hF);
        rxTest(8'h90, 4'h0, 4'hF);
        rxTest(8'h03, 4'hA, 4'hB);
        rxTest(8'h90, 4'h0, 4'hF);
        rxTest(8'h04, 4'h0, 4'hB);
        rxTest(8'h90, 4'h0, 4'hF);
        rxTest(8'h55, 4'h3, 4'h3);
        rd(OFF_STATUS, rdv);
        chk(rdv & 16'h0003, 16'h0003);
        for (int i = 0; i < 8; i++) begin
            c = 8'(rnd());
            if (c == 8'h90 || c == 8'hB2) c = 8'h41;
            rxTest(c, 4'hC, 4'hF);
        end
        wr(OFF_MODE, 16'h000C);
        rxTest(8'h41, 4'h0, 4'hF);
        wr(OFF_MODE, 16'h0004);
        wr(OFF_DLE_CHAR, 16'h0090);
        rxTest(8'h90, 4'hC, 4'hF);
        $display("receive test done");
        wr(OFF_DLE_CHAR, 16'h8090);
        pat = rnd();
        wr(OFF_SYNC_PATTERN, pat);
        wr(OFF_MODE, 16'h0007);
        pulseFrame();
        i_remote.grabBits(v, ok);
        chk(v, pat);
        chk(16'(ok), 16'h0001);
        for (int i = 0; i < 50 && txCharReady !== 1'b1; i++) @(posedge clk);
        #1;
        chk(16'(txCharReady), 16'h0001);
        @(posedge clk);
        txChar <= 8'(rnd());
        txUnderrun <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            i_remote.grabBits(v, ok);
            chk(v, 16'hB290);
            chk(16'(ok), 16'h0001);
        end
        // a new character ends the fill after the next sync character
        @(posedge clk);
        txUnderrun <= 1'b0;
        txCharValid <= 1'b1;
        for (int i = 0; i < 40 && txCharReady !== 1'b1; i++) @(posedge clk);
        #1;
        chk(16'(txCharReady), 16'h0001);
        @(posedge clk);
        txCharValid <= 1'b0;
        rd(OFF_STATUS, rdv);
        chk(rdv & 16'h0008, 16'h0008);
        $display("transmit test done");
        doReset();
        wr(OFF_SYNC_PATTERN, 16'h5A5A);
        wr(OFF_MODE, 16'h0000);
        pulseFrame();
        n = 0;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            #1;
            if (txBitValid !== 1'b0) n++;
        end
        chk(16'(n), 16'h0000);
        chk(16'(txCharReady), 16'h0001);
        $display("no pattern test done");
        end_of_test();
    end
endmodule
